/* File: bench/sep_host.sv */
// Host controller model for the three-wire serial link
`timescale 1ns/10ps

module sep_host (
  // Reference clock
  input  wire logic i_ref_clk,
  // Device output pin
  input  wire logic i_serial_out,
  input  wire logic i_serial_out_oe,
  // Link pins and resolved output level
  output logic      o_select_line,
  output logic      o_serial_clk,
  output logic      o_serial_in,
  output logic      o_pin
);
  logic last_q = 1'b0;
  // Released line shows the inverse of its last level, never a stale match
  assign o_pin = i_serial_out_oe ? i_serial_out : ~last_q;
  always_ff @(posedge i_ref_clk) begin
    if (i_serial_out_oe) begin
      last_q <= i_serial_out;
    end
  end
  initial begin
    o_select_line = 1'b0;
    o_serial_clk  = 1'b0;
    o_serial_in   = 1'b0;
  end
  task automatic select(input logic on);
    o_select_line <= on;
    repeat (10) @(posedge i_ref_clk);
  endtask : select
  // Data moves while clock is low, held 5 cycles each side of the edge
  task automatic shift(input logic [31:0] v, input int n, output logic [31:0] got);
    got = 32'h0;
    for (int i = n - 1; i >= 0; i--) begin
      o_serial_clk <= 1'b0;
      o_serial_in  <= v[i];
      repeat (4) @(posedge i_ref_clk);
      @(negedge i_ref_clk);
      got = {got[30:0], o_pin};
      @(posedge i_ref_clk);
      o_serial_clk <= 1'b1;
      repeat (5) @(posedge i_ref_clk);
    end
    o_serial_clk <= 1'b0;
  endtask : shift
endmodule : sep_host

/* File: bench/sep_top_chk.sv */
// Port checker for the serial command port
`timescale 1ns/10ps

module sep_top_chk #(
  parameter int P_TWL_CYC = 300000
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_select_line,
  input wire logic i_serial_clk,
  input wire logic i_serial_in,
  input wire logic o_serial_out,
  input wire logic o_serial_out_oe,
  input wire logic i_word_width_select
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  logic [19:0] busy_q;
  // Low status with clock parked; read zeros reset it at each clock high
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_q <= 20'h0;
    end else begin
      busy_q <= (o_serial_out_oe && !o_serial_out && !i_serial_clk) ? busy_q + 20'h1 : 20'h0;
    end
  end
  sequence parked_s;
    (i_select_line && !i_serial_clk) [*5];
  endsequence
  fall_float_a: assert property ($fell(i_select_line) |-> ##[1:6] !o_serial_out_oe)
    else $error("serial out still driven after deselect");
  idle_float_a: assert property (!i_select_line [*8] |-> !o_serial_out_oe)
    else $error("serial out driven while deselected");
  rise_sel_a: assert property ($rose(o_serial_out_oe) |-> i_select_line && $past(i_select_line))
    else $error("serial out enabled without select");
  out_edge_a: assert property ($fell(o_serial_out) && o_serial_out_oe && $past(o_serial_out_oe)
    |-> $past(i_serial_clk, 2))
    else $error("read bit changed away from a clock edge");
  reset_quiet_a: assert property ($rose(i_rst_n) |-> !o_serial_out_oe ##1 !o_serial_out_oe)
    else $error("serial out driven right after reset");
  ready_stands_a: assert property (parked_s ##0 (o_serial_out_oe && o_serial_out)
    |=> o_serial_out || !o_serial_out_oe)
    else $error("ready status dropped");
  busy_bound_a: assert property (busy_q <= P_TWL_CYC)
    else $error("busy status held too long");
  status_low_a: assert property (parked_s ##0 (o_serial_out_oe && !o_serial_out)
    |=> o_serial_out_oe || !i_select_line)
    else $error("busy status vanished with select high");
endmodule : sep_top_chk

bind sep_top sep_top_chk #(.P_TWL_CYC(P_TWL_CYC)) u_chk (
  .i_ref_clk(i_ref_clk),
  .i_rst_n(i_rst_n),
  .i_select_line(i_select_line),
  .i_serial_clk(i_serial_clk),
  .i_serial_in(i_serial_in),
  .o_serial_out(o_serial_out),
  .o_serial_out_oe(o_serial_out_oe),
  .i_word_width_select(i_word_width_select)
);

/* File: bench/serial_eeprom_command_port_bench.sv */
// Self-checking bench for the serial command port
`timescale 1ns/10ps

module serial_eeprom_command_port_bench;
  import sep_pkg::*;
  localparam int P_WC  = 200;
  localparam int P_TEC = 1200;
  localparam int P_TWL = 1300;
  logic        ref_clk;
  logic        rst_n;
  logic        word_sel;
  logic        sel;
  logic        sclk;
  logic        sin;
  logic        pin;
  logic        so;
  logic        so_oe;
  logic [31:0] lfsr_q   = 32'h00fa;
  logic [31:0] got;
  logic [15:0] d0;
  logic [15:0] d1;
  logic [15:0] v;
  int          fails    = 0;
  int          tests_run = 0;
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  sep_top #(.P_TWC_LOW_V_CYC(P_WC), .P_TEC_CYC(P_TEC), .P_TWL_CYC(P_TWL)) u_dut (
    .i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_select_line(sel), .i_serial_clk(sclk),
    .i_serial_in(sin), .o_serial_out(so), .o_serial_out_oe(so_oe),
    .i_word_width_select(word_sel));
  sep_host u_host (.i_ref_clk(ref_clk), .i_serial_out(so), .i_serial_out_oe(so_oe),
    .o_select_line(sel), .o_serial_clk(sclk), .o_serial_in(sin), .o_pin(pin));
  task automatic summarize;
    if (fails == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize
  task automatic compare(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : compare
  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_step
  // Byte mode hands back only the low byte of what was written
  function automatic logic [15:0] exp_rd(input logic [15:0] d, input logic x16);
    return x16 ? d : {8'h0, d[7:0]};
  endfunction : exp_rd
  // Sub-code goes in the two leading bits of the field
  function automatic logic [9:0] ext(input logic [1:0] s);
    return {s, 8'h0};
  endfunction : ext
  // Frame lengths: 13/29 clocks for words, 14/22 for bytes
  task automatic send(input logic [1:0] op, input logic [9:0] a, input logic [15:0] d,
                      input logic dat);
    logic [31:0] f;
    logic [9:0]  fw;
    logic [10:0] fb;
    fw = (op == OP_EXT) ? a : {1'b0, a[8:0]};
    fb = (op == OP_EXT) ? {a, 1'b0} : {1'b0, a};
    f  = word_sel ? {20'h1, op, fw} : {19'h1, op, fb};
    if (dat) begin
      f = word_sel ? {f[15:0], d} : {f[23:0], d[7:0]};
    end
    u_host.select(1'b1);
    u_host.shift(f, word_sel ? (dat ? 29 : 13) : (dat ? 22 : 14), got);
  endtask : send
  // Status low at once, high within the self-timed bound
  task automatic prog(input logic [1:0] op, input logic [9:0] a, input logic [15:0] d,
                      input logic dat, input int lim);
    int n;
    send(op, a, d, dat);
    @(negedge ref_clk);
    compare({so_oe, pin}, 2'b10);
    for (n = 0; n < lim + 40 && pin !== 1'b1; n++) @(negedge ref_clk);
    compare(n <= lim, 1'b1);
    compare({so_oe, pin}, 2'b11);
    @(posedge ref_clk);
    u_host.select(1'b0);
  endtask : prog
  task automatic quiet(input logic [1:0] op, input logic [9:0] a, input logic [15:0] d,
                       input logic dat);
    send(op, a, d, dat);
    @(negedge ref_clk);
    compare(so_oe, 1'b0);
    @(posedge ref_clk);
    u_host.select(1'b0);
  endtask : quiet
  // Leaves select high so sequential reads may follow
  task automatic rd(input logic [9:0] a, output logic [15:0] r);
    send(OP_READ, a, 16'h0, 1'b0);
    u_host.shift(32'h0, word_sel ? 17 : 9, got);
    compare(word_sel ? got[16] : got[8], 1'b0);
    r = word_sel ? got[15:0] : {8'h0, got[7:0]};
  endtask : rd
  initial begin
    repeat (60000) @(posedge ref_clk);
    fails++;
    summarize;
  end
  initial begin
    rst_n    = 1'b0;
    word_sel = 1'b1;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    compare(so_oe, 1'b0);
    u_host.select(1'b1);
    u_host.shift(32'h0, 20, got);
    compare(so_oe, 1'b0);
    u_host.select(1'b0);
    lfsr_q = lfsr_step(lfsr_q);
    d0     = lfsr_q[15:0];
    lfsr_q = lfsr_step(lfsr_q);
    d1     = lfsr_q[15:0];
    quiet(OP_WRITE, 10'h5, d0, 1'b1);
    quiet(OP_EXT, ext(SUB_UNLOCK), 16'h0, 1'b0);
    prog(OP_WRITE, 10'h5, d0, 1'b1, P_WC);
    rd(10'h5, v);
    u_host.select(1'b0);
    compare(v, d0);
    prog(OP_ERASE, 10'h5, 16'h0, 1'b0, P_WC);
    rd(10'h5, v);
    u_host.select(1'b0);
    compare(v, ERASED_WORD);
    prog(OP_WRITE, 10'h1ff, d0, 1'b1, P_WC);
    prog(OP_WRITE, 10'h0, d1, 1'b1, P_WC);
    rd(10'h1ff, v);
    compare(v, d0);
    u_host.shift(32'h0, 16, got);
    u_host.select(1'b0);
    compare(got[15:0], d1);
    u_host.select(1'b1);
    u_host.shift({12'h0, 13'h1400, 7'h2a}, 20, got);
    u_host.select(1'b0);
    quiet(OP_EXT, ext(SUB_LOCK), 16'h0, 1'b0);
    quiet(OP_WRITE, 10'h0, ~d1, 1'b1);
    quiet(OP_ERASE, 10'h0, 16'h0, 1'b0);
    rd(10'h0, v);
    u_host.select(1'b0);
    compare(v, d1);
    word_sel <= 1'b0;
    @(posedge ref_clk);
    quiet(OP_EXT, ext(SUB_UNLOCK), 16'h0, 1'b0);
    prog(OP_WRITE, 10'h3, d0, 1'b1, P_WC);
    rd(10'h3, v);
    u_host.select(1'b0);
    compare(v, exp_rd(d0, 1'b0));
    word_sel <= 1'b1;
    @(posedge ref_clk);
    prog(OP_EXT, ext(SUB_FILL_ALL), d1, 1'b1, P_TWL);
    rd(d0[9:0], v);
    u_host.select(1'b0);
    compare(v, d1);
    prog(OP_EXT, ext(SUB_ERASE_ALL), 16'h0, 1'b0, P_TEC);
    rd(d1[9:0], v);
    u_host.select(1'b0);
    compare(v, ERASED_WORD);
    summarize;
  end
endmodule : serial_eeprom_command_port_bench

/* File: core/sep_pkg.sv */
// Constants and types for the serial nonvolatile memory command port
package sep_pkg;
  // Reference clock rate
  localparam int CLK_MHZ = 20;
  // Self-timed durations, in microseconds
  localparam int TWC_LOW_V_US                = 5000;
  localparam int TWC_FIVE_V_US               = 2000;
  localparam int ERASE_EVERYTHING_TIME_US    = 6000;
  localparam int FILL_EVERYTHING_TIME_US     = 15000;
  // Longest times round down; these divide exactly
  localparam int TWC_LOW_V_CYC               = TWC_LOW_V_US * CLK_MHZ;
  localparam int TWC_FIVE_V_CYC              = TWC_FIVE_V_US * CLK_MHZ;
  localparam int ERASE_EVERYTHING_TIME_CYC   = ERASE_EVERYTHING_TIME_US * CLK_MHZ;
  localparam int FILL_EVERYTHING_TIME_CYC    = FILL_EVERYTHING_TIME_US * CLK_MHZ;
  localparam int TMR_W                       = 19;
  // Frame layout: bits after the start bit
  localparam logic [4:0] HDR_X16             = 5'h0c;
  localparam logic [4:0] HDR_X8              = 5'h0d;
  localparam logic [4:0] DAT_X16             = 5'h10;
  localparam logic [4:0] DAT_X8              = 5'h08;
  localparam logic [3:0] BITS_X16_M1         = 4'hf;
  localparam logic [3:0] BITS_X8_M1          = 4'h7;
  // Opcodes and extended sub-codes
  localparam logic [1:0] OP_READ             = 2'h2;
  localparam logic [1:0] OP_WRITE            = 2'h1;
  localparam logic [1:0] OP_ERASE            = 2'h3;
  localparam logic [1:0] OP_EXT              = 2'h0;
  localparam logic [1:0] SUB_UNLOCK          = 2'h3;
  localparam logic [1:0] SUB_ERASE_ALL       = 2'h2;
  localparam logic [1:0] SUB_FILL_ALL        = 2'h1;
  localparam logic [1:0] SUB_LOCK            = 2'h0;
  localparam logic [15:0] ERASED_WORD        = 16'hffff;
  // Reset value and last sweep index
  localparam logic        UNLOCK_RST         = 1'b0;
  localparam logic [9:0]  SWEEP_LAST         = 10'h3ff;
  // Read-ahead buffer shape
  localparam int FIFO_WIDTH                  = 16;
  localparam int FIFO_DEPTH                  = 8;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_SHIFT = 3'h2,
    ST_READ  = 3'h4
  } sep_frame_type;
endpackage : sep_pkg

/* File: core/sep_top.sv */
// Serial nonvolatile memory command port with read-ahead buffer
// Functional notes
// - Word width strap high gives 16-bit words, low gives 8-bit bytes.
// - All command, address and data bits sampled on rising serial clock.
// - Serial out floats except during read data or ready/busy status.
// - Status drives low while programming runs, high when ready.
// - Select falling forces serial out to float three reference clocks later.
// - Start bit is first rising clock with select and serial in high; none is taken while a self-timed cycle runs.
// - Nothing happens before a start bit is seen.
// - Standby is left as soon as select goes high.
// - Instruction executes only after its full bit count arrives.
// - Word frame: start, opcode, ignored bit, 9 address, 16 data bits.
// - Byte frame: start, opcode, ignored bit, 10 address, 8 data bits.
// - Opcode 10 reads, 01 writes, 11 erases one location.
// - Opcode 00 sub-codes: 11 unlock, 10 erase all, 01 fill all, 00 lock.
// - Read data MSB first; status after programming; float after lock/unlock.
// - Low-voltage single erase or write lasts at most 5 ms.
// - Five-volt-only single erase or write lasts at most 2 ms.
// - Erase everything within 6 ms, fill everything within 15 ms.
// - Programming locked after power-up until unlock executes.
// - Single erase sets every bit of the location to one.
// - With select held high, read continues with following locations.
// - Fill everything erases the array first, only when unlocked.
`timescale 1ns/10ps

module sep_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_flush,
  // Fill side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // Drain side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  wire              push_w = i_in_valid & o_in_ready;
  wire              pop_w  = o_out_valid & i_out_ready;

  assign o_out_valid = (wr_q != rd_q);
  assign o_in_ready  = ~((wr_q[AW-1:0] == rd_q[AW-1:0]) & (wr_q[AW] != rd_q[AW]));
  assign o_out_data  = mem[rd_q[AW-1:0]];

  // Flush wins over a push in the same cycle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else if (i_flush) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push_w) wr_q <= wr_q + 1'b1;
      if (pop_w)  rd_q <= rd_q + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (push_w) mem[wr_q[AW-1:0]] <= i_in_data;
  end
endmodule : sep_fifo

module sep_top #(
  parameter int P_FIVE_VOLT_ONLY = 0,
  parameter int P_TWC_LOW_V_CYC  = sep_pkg::TWC_LOW_V_CYC,
  parameter int P_TWC_FIVE_V_CYC = sep_pkg::TWC_FIVE_V_CYC,
  parameter int P_TEC_CYC        = sep_pkg::ERASE_EVERYTHING_TIME_CYC,
  parameter int P_TWL_CYC        = sep_pkg::FILL_EVERYTHING_TIME_CYC
) (
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rst_n,
  // Serial link pins
  input  wire logic i_select_line,
  input  wire logic i_serial_clk,
  input  wire logic i_serial_in,
  output logic      o_serial_out,
  output logic      o_serial_out_oe,
  // Organisation strap
  input  wire logic i_word_width_select
);
  import sep_pkg::*;

  function automatic logic [TMR_W-1:0] to_tmr(input int cyc);
    to_tmr = TMR_W'(cyc - 1);
  endfunction : to_tmr

  localparam int TWC_CYC = (P_FIVE_VOLT_ONLY != 0) ? P_TWC_FIVE_V_CYC : P_TWC_LOW_V_CYC;

  // Reset release and pin synchronisers
  logic [1:0] rst_sync_q;
  logic [3:0] sy1_q;
  logic [3:0] sy2_q;
  logic       sclk_prev_q;
  wire        rst_n = rst_sync_q[1];

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) rst_sync_q <= 2'h0;
    else          rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sy1_q       <= 4'h0;
      sy2_q       <= 4'h0;
      sclk_prev_q <= 1'b0;
    end else begin
      sy1_q       <= {i_word_width_select, i_serial_clk, i_serial_in, i_select_line};
      sy2_q       <= sy1_q;
      sclk_prev_q <= sy2_q[2];
    end
  end

  wire cs_w   = sy2_q[0];
  wire din_w  = sy2_q[1];
  wire org_w  = sy2_q[3];
  // Serial clock is oversampled; it must stay well under a quarter of the ref clock
  wire edge_w = sy2_q[2] & ~sclk_prev_q & cs_w;

  // Frame state
  sep_frame_type frame_q;
  logic [27:0]   sh_in_q;
  logic [4:0]    cnt_q;
  logic          org_q;
  logic [1:0]    op_q;
  logic [9:0]    adr_q;
  logic          unlocked_q;
  logic          armed_q;
  logic          busy_q;

  wire [27:0] nxt_w   = {sh_in_q[26:0], din_w};
  wire [4:0]  n_w     = cnt_q + 5'h01;
  wire [4:0]  hdr_w   = org_q ? HDR_X16 : HDR_X8;
  wire [4:0]  dlen_w  = org_q ? DAT_X16 : DAT_X8;
  wire [1:0]  op_w    = org_q ? nxt_w[11:10] : nxt_w[12:11];
  // Sub-code rides in the two leading field bits, ignored position included
  wire [1:0]  sub_w   = org_q ? nxt_w[9:8] : nxt_w[10:9];
  wire [9:0]  adr_w   = org_q ? {1'b0, nxt_w[8:0]} : nxt_w[9:0];
  wire [15:0] dat_w   = org_q ? nxt_w[15:0] : {nxt_w[7:0], nxt_w[7:0]};
  wire        in_sh_w = edge_w & (frame_q == ST_SHIFT);
  wire        at_hdr  = in_sh_w & (n_w == hdr_w);
  wire        at_end  = in_sh_w & (n_w == hdr_w + dlen_w);
  wire        ext_w   = at_hdr & (op_w == OP_EXT);
  wire        hdr_rd  = at_hdr & (op_w == OP_READ);
  wire        need_dt = (op_w == OP_WRITE) | ((op_w == OP_EXT) & (sub_w == SUB_FILL_ALL));
  wire        go_unlk = ext_w & (sub_w == SUB_UNLOCK);
  wire        go_lock = ext_w & (sub_w == SUB_LOCK);
  wire        go_er1  = at_hdr & (op_w == OP_ERASE) & unlocked_q;
  wire        go_erase_everything = ext_w & (sub_w == SUB_ERASE_ALL) & unlocked_q;
  wire        go_wr1  = at_end & (op_q == OP_WRITE) & unlocked_q;
  wire        go_fill_everything = at_end & (op_q == OP_EXT) & unlocked_q;
  wire        issue_w = go_er1 | go_erase_everything | go_wr1 | go_fill_everything;
  // Start is not taken while a self-timed cycle runs
  wire        start_w = edge_w & (frame_q == ST_IDLE) & din_w & ~busy_q;

  // Select low holds the command logic idle
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_q <= ST_IDLE;
      sh_in_q <= 28'h0;
      cnt_q   <= 5'h00;
      org_q   <= 1'b0;
      op_q    <= 2'h0;
      adr_q   <= 10'h000;
    end else if (!cs_w) begin
      frame_q <= ST_IDLE;
    end else begin
      case (frame_q)
        ST_IDLE: begin
          if (start_w) begin
            frame_q <= ST_SHIFT;
            cnt_q   <= 5'h00;
            org_q   <= org_w;
          end
        end
        ST_SHIFT: begin
          if (in_sh_w) begin
            sh_in_q <= nxt_w;
            cnt_q   <= n_w;
          end
          if (at_hdr) begin
            op_q  <= op_w;
            adr_q <= adr_w;
            if (op_w == OP_READ) frame_q <= ST_READ;
            else if (!need_dt)   frame_q <= ST_IDLE;
          end
          if (at_end) frame_q <= ST_IDLE;
        end
        ST_READ: frame_q <= ST_READ;
        default: frame_q <= ST_IDLE;
      endcase
    end
  end

  // Lock and status arming; arming wins over a same-cycle start
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      unlocked_q <= UNLOCK_RST;
      armed_q    <= 1'b0;
    end else begin
      if (go_unlk)      unlocked_q <= 1'b1;
      else if (go_lock) unlocked_q <= 1'b0;
      armed_q <= issue_w | (armed_q & ~start_w);
    end
  end

  // Self-timed programming engine
  logic [TMR_W-1:0] tmr_q;
  logic [9:0]       swp_q;
  logic             swp_on_q;
  logic             fill_q;
  logic             pend_q;
  logic             pg_org_q;
  logic [9:0]       pg_adr_q;
  logic [15:0]      pg_dat_q;

  wire [TMR_W-1:0] tmr_ld_w = go_erase_everything ? to_tmr(P_TEC_CYC) :
                              go_fill_everything ? to_tmr(P_TWL_CYC) : to_tmr(TWC_CYC);

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q   <= 1'b0;
      tmr_q    <= '0;
      swp_q    <= 10'h000;
      swp_on_q <= 1'b0;
      fill_q   <= 1'b0;
      pend_q   <= 1'b0;
      pg_org_q <= 1'b0;
      pg_adr_q <= 10'h000;
      pg_dat_q <= 16'h0000;
    end else if (issue_w) begin
      busy_q   <= 1'b1;
      tmr_q    <= tmr_ld_w;
      swp_q    <= 10'h000;
      swp_on_q <= go_erase_everything | go_fill_everything;
      fill_q   <= go_fill_everything;
      pend_q   <= go_er1 | go_wr1;
      pg_org_q <= org_q;
      pg_adr_q <= go_wr1 ? adr_q : adr_w;
      pg_dat_q <= go_er1 ? ERASED_WORD : dat_w;
    end else begin
      pend_q <= 1'b0;
      if (busy_q) begin
        if (tmr_q == '0) busy_q <= 1'b0;
        else             tmr_q  <= tmr_q - 1'b1;
      end
      if (swp_on_q) begin
        swp_q <= swp_q + 10'h001;
        if (swp_q == SWEEP_LAST) swp_on_q <= 1'b0;
      end
    end
  end

  // Array as two byte banks; sweep pass 0 erases, pass 1 fills for fill everything and erases again for erase all
  logic [7:0] even_mem [512];
  logic [7:0] odd_mem  [512];
  wire        fill_ph_w = swp_q[9] & fill_q;
  wire [8:0]  widx_w    = swp_on_q ? swp_q[8:0] : (pg_org_q ? pg_adr_q[8:0] : pg_adr_q[9:1]);
  wire [15:0] wdat_w    = (swp_on_q & ~fill_ph_w) ? ERASED_WORD : pg_dat_q;
  wire        we_even_w = swp_on_q | (pend_q & (pg_org_q | ~pg_adr_q[0]));
  wire        we_odd_w  = swp_on_q | (pend_q & (pg_org_q | pg_adr_q[0]));

  always_ff @(posedge i_ref_clk) begin
    if (we_even_w) even_mem[widx_w] <= wdat_w[15:8];
    if (we_odd_w)  odd_mem[widx_w]  <= wdat_w[7:0];
  end

  // Read-ahead into the buffer; stalls when it fills
  logic        pf_on_q;
  logic [9:0]  pf_adr_q;
  logic        fifo_rdy;
  logic        fifo_vld;
  logic [15:0] fifo_dat;
  logic        do_q;
  logic        oe_q;
  logic [3:0]  bcnt_q;
  logic [15:0] osh_q;

  wire [7:0]  byte_w   = pf_adr_q[0] ? odd_mem[pf_adr_q[9:1]] : even_mem[pf_adr_q[9:1]];
  wire [15:0] rword_w  = org_q ? {even_mem[pf_adr_q[8:0]], odd_mem[pf_adr_q[8:0]]}
                               : {byte_w, 8'h00};
  wire [9:0]  pf_inc_w = pf_adr_q + 10'h001;
  wire [9:0]  pf_nxt_w = org_q ? {1'b0, pf_inc_w[8:0]} : pf_inc_w;
  wire        push_w   = pf_on_q & fifo_rdy;
  wire        flush_w  = ~cs_w | hdr_rd;
  wire        rd_edge  = edge_w & (frame_q == ST_READ);
  wire        pop_w    = rd_edge & (bcnt_q == 4'h0);

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pf_on_q  <= 1'b0;
      pf_adr_q <= 10'h000;
    end else if (flush_w) begin
      pf_on_q  <= hdr_rd;
      pf_adr_q <= adr_w;
    end else if (push_w) begin
      pf_adr_q <= pf_nxt_w;
    end
  end

  sep_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_ref_clk),
    .i_rst_n     (rst_n),
    .i_flush     (flush_w),
    .i_in_valid  (pf_on_q),
    .i_in_data   (rword_w),
    .o_in_ready  (fifo_rdy),
    .o_out_valid (fifo_vld),
    .i_out_ready (pop_w),
    .o_out_data  (fifo_dat)
  );

  // Serial output driver
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      do_q   <= 1'b0;
      oe_q   <= 1'b0;
      bcnt_q <= 4'h0;
      osh_q  <= 16'h0000;
    end else if (!cs_w) begin
      oe_q <= 1'b0;
    end else if (hdr_rd) begin
      oe_q   <= 1'b1;
      do_q   <= 1'b0;
      bcnt_q <= 4'h0;
    end else if (rd_edge) begin
      if (bcnt_q == 4'h0) begin
        do_q   <= fifo_vld ? fifo_dat[15] : 1'b0;
        osh_q  <= {fifo_dat[14:0], 1'b0};
        bcnt_q <= org_q ? BITS_X16_M1 : BITS_X8_M1;
      end else begin
        do_q   <= osh_q[15];
        osh_q  <= {osh_q[14:0], 1'b0};
        bcnt_q <= bcnt_q - 4'h1;
      end
    end else if (frame_q != ST_READ) begin
      oe_q <= armed_q & (frame_q == ST_IDLE);
      do_q <= ~busy_q;
    end
  end

  assign o_serial_out    = do_q;
  assign o_serial_out_oe = oe_q;
endmodule : sep_top
